// ==== design/adc_ctrl_params.svh ====
/*
 * Constants for the converter control block: register offsets, field
 * positions, reset values and timing figures.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH

// ==========================================================
// Register offsets (byte addresses on the bus)
`define OFS_CTRL_EXT     8'h92
`define OFS_MAIN_CTRL    8'h93
`define OFS_TIMING       8'h94
`define OFS_PIN_EN       8'h95
`define OFS_RES_LOW      8'h96
`define OFS_RES_HIGH     8'h97
`define OFS_IRQ_STATUS   8'ha0
`define OFS_IRQ_MASK     8'ha4

// ==========================================================
// Main control fields
`define MC_POWER         7
`define MC_FLAG          6
`define MC_CMP_EN        5
`define MC_REF_SEL       4
`define MC_GO            0
// Extension control fields
`define CE_WIDTH_SEL     2
`define CE_PIN8_EN       1
`define CE_CHAN_MSB      0

// ==========================================================
// Reset values
`define RST_BYTE         8'h00
`define MAIN_RST         8'h00

// ==========================================================
// Timing and channel codes
`define SAMPLE_MIN       4'h2
`define SAMPLE_MAX       4'hf
`define CONV_BITS        4'hc
`define INT_REF_CODE     2'h3
`define LAST_CHAN        4'h8

`endif

// ==== design/adc_ctrl_pkg.sv ====
/*
 * Types shared by the converter control block.
 * Assumes no surroundings beyond the header of constants.
 */
package adc_ctrl_pkg;
   // Conversion sequencer states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SAMPLE,
      ST_CONVERT
   } conv_state_e;
endpackage

// ==== design/sar_adc_control_compare.sv ====
/*
 * Control and result logic for a 12-bit successive-approximation converter:
 * register file on Avalon-MM, channel/reference routing, clock divider,
 * sample phase, result packing, compare mode and interrupt.
 * Assumes an analog core that, when told to sample and then convert, offers
 * a 12-bit code and a compare outcome; its bit decisions are paced here.
 */
// The implementer's own choice: the Avalon-MM slave port.
// Contract
// - channel code from msb plus low field
// - go bit starts; hardware clears on completion
// - clearing go mid-conversion aborts it
// - compare mode keeps go set, continuous
// - reference select picks external pin
// - width select packs 12-bit or 10-bit
// - pin8 enable ignored under external reference
// - divider field sets clock period
// - polarity picks above or below compare
// - sample phase field+1, clamped 2..15
// - conversion is sample plus twelve periods
// - pin enable bits select analog pins
// - results load only on completion
// - operates only while powered on
// - completion or compare sets sticky flag
`timescale 1ns/1ns
`include "adc_ctrl_params.svh"

module sar_adc_control_compare (
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   // Avalon-MM slave
   input  wire logic [7:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   output logic             irq,
   // Analog front end
   output logic [3:0]       chan_code,
   output logic             int_ref_route,
   output logic             ext_ref_pin_en,
   output logic [8:0]       pin_analog_mode,
   output logic             adc_enable,
   output logic             sample_en,
   output logic             conv_step,
   input  wire logic [11:0] core_result,
   input  wire logic        core_above,
   input  wire logic        core_below
);

   // ==========================================================
   // Reset synchroniser
   logic rst_meta_q;   // First stage
   logic rst_sync_n_q; // Released reset used throughout

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_q   <= 1'b0;
         rst_sync_n_q <= 1'b0;
      end else begin
         rst_meta_q   <= 1'b1;
         rst_sync_n_q <= rst_meta_q;
      end
   end

   // ==========================================================
   // Register storage
   logic [7:0]  main_q;        // Power, compare enable, ref sel, channel low, go
   logic [2:0]  ext_q;         // Width select, pin8 enable, channel msb
   logic [7:0]  timing_q;      // Divider, polarity, sample length
   logic [7:0]  pin_en_q;      // Pin analog enables
   logic [11:0] result_q;      // Result or compare value
   logic [1:0]  irq_stat_q;    // Sticky: [0] conversion done, [1] compare hit
   logic [1:0]  irq_mask_q;    // Enables for status bits
   logic        flag_q;        // Converter interrupt flag
   logic        ack_q;         // One-cycle answer to a request

   // Bus decode: each access answers one cycle after it is seen.
   // Writes land on the edge where waitrequest is seen low; read data is
   // captured one edge earlier so that it stands at that same edge.
   logic wr_fire;
   logic rd_fire;
   assign wr_fire     = write & ack_q;
   assign rd_fire     = read & ~ack_q;
   assign waitrequest = (read | write) & ~ack_q;

   // Sequencer events
   adc_ctrl_pkg::conv_state_e state_q;
   logic conv_done;   // Conversion finished this cycle
   logic cmp_done;    // Compare pass finished this cycle
   logic cmp_hit;     // Compare condition met at end of pass

   // Register-write helpers
   logic wr_main;
   assign wr_main = wr_fire & byteenable[0] & (address == `OFS_MAIN_CTRL);

   // ==========================================================
   // Acknowledge: waitrequest drops for exactly one cycle per access
   always_ff @(posedge core_clk or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (read | write) & ~ack_q;
      end
   end

   // ==========================================================
   // Main control: go bit cleared by hardware on completion outside compare mode, and in any mode while power is off
   always_ff @(posedge core_clk or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         main_q <= `MAIN_RST;
      end else begin
         if (wr_main) begin
            main_q <= writedata[7:0];
         end
         if (conv_done && !main_q[`MC_CMP_EN] && !wr_main) begin
            main_q[`MC_GO] <= 1'b0;
         end
         if (!main_q[`MC_POWER] && !wr_main) begin
            main_q[`MC_GO] <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Interrupt flag: set wins over a software clear
   always_ff @(posedge core_clk or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         flag_q <= 1'b0;
      end else if (conv_done || cmp_hit) begin
         flag_q <= 1'b1;
      end else if (wr_main) begin
         flag_q <= writedata[`MC_FLAG];
      end
   end

   // ==========================================================
   // Other configuration registers
   always_ff @(posedge core_clk or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         ext_q      <= 3'h0;
         timing_q   <= `RST_BYTE;
         pin_en_q   <= `RST_BYTE;
         irq_mask_q <= 2'h0;
      end else if (wr_fire && byteenable[0]) begin
         case (address)
            `OFS_CTRL_EXT:  ext_q      <= writedata[2:0];
            `OFS_TIMING:    timing_q   <= writedata[7:0];
            `OFS_PIN_EN:    pin_en_q   <= writedata[7:0];
            `OFS_IRQ_MASK:  irq_mask_q <= writedata[1:0];
            default:        ;
         endcase
      end
   end

   // ==========================================================
   // Result registers: converter writes on completion only; software
   // writes set the compare value
   logic [11:0] packed_res;
   always_comb begin
      packed_res = core_result;
      if (ext_q[`CE_WIDTH_SEL]) begin
         // Ten-bit code: top byte unchanged, its two low bits at the bottom
         packed_res = {core_result[11:4], 2'h0, core_result[3:2]};
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         result_q <= 12'h000;
      end else if (conv_done) begin
         result_q <= packed_res;
      end else if (wr_fire && byteenable[0] && address == `OFS_RES_LOW) begin
         result_q[3:0] <= writedata[3:0];
      end else if (wr_fire && byteenable[0] && address == `OFS_RES_HIGH) begin
         result_q[11:4] <= writedata[7:0];
      end
   end

   // ==========================================================
   // Interrupt status: sticky, cleared by reading; a new event wins
   always_ff @(posedge core_clk or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         irq_stat_q <= 2'h0;
      end else begin
         irq_stat_q <= ((rd_fire && address == `OFS_IRQ_STATUS) ? 2'h0 : irq_stat_q)
                       | {cmp_hit, conv_done};
      end
   end

   assign irq = |(irq_stat_q & irq_mask_q);

   // ==========================================================
   // Read data, registered
   always_ff @(posedge core_clk or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         readdata <= 32'h0000_0000;
      end else if (rd_fire) begin
         case (address)
            `OFS_MAIN_CTRL:  readdata <= {24'h0, main_q[7], flag_q, main_q[5:0]};
            `OFS_CTRL_EXT:   readdata <= {29'h0, ext_q};
            `OFS_TIMING:     readdata <= {24'h0, timing_q};
            `OFS_PIN_EN:     readdata <= {24'h0, pin_en_q};
            `OFS_RES_LOW:    readdata <= {28'h0, result_q[3:0]};
            `OFS_RES_HIGH:   readdata <= {24'h0, result_q[11:4]};
            `OFS_IRQ_STATUS: readdata <= {30'h0, irq_stat_q};
            `OFS_IRQ_MASK:   readdata <= {30'h0, irq_mask_q};
            default:         readdata <= 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // Routing to the analog front end
   logic ext_ref;
   assign ext_ref = main_q[`MC_REF_SEL];

   always_ff @(posedge core_clk or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         chan_code       <= 4'h0;
         int_ref_route   <= 1'b0;
         ext_ref_pin_en  <= 1'b0;
         pin_analog_mode <= 9'h000;
         adc_enable      <= 1'b0;
      end else begin
         chan_code       <= {ext_q[`CE_CHAN_MSB], main_q[3:1]};
         int_ref_route   <= ({ext_q[`CE_CHAN_MSB], main_q[3]} == `INT_REF_CODE);
         ext_ref_pin_en  <= ext_ref;
         // Under external reference the shared pin serves the reference
         pin_analog_mode <= {ext_q[`CE_PIN8_EN] & ~ext_ref, pin_en_q};
         adc_enable      <= main_q[`MC_POWER];
      end
   end

   // ==========================================================
   // Converter clock divider
   logic [5:0] div_len;
   always_comb begin
      case (timing_q[7:5])
         3'h0:    div_len = 6'h02;
         3'h1:    div_len = 6'h04;
         3'h2:    div_len = 6'h06;
         3'h3:    div_len = 6'h08;
         3'h4:    div_len = 6'h0c;
         3'h5:    div_len = 6'h10;
         3'h6:    div_len = 6'h18;
         default: div_len = 6'h20;
      endcase
   end

   logic [5:0] div_q;
   logic       tick;   // One system clock per converter period
   assign tick = (div_q == div_len - 6'h01);

   logic running;
   assign running = main_q[`MC_GO] & main_q[`MC_POWER];

   always_ff @(posedge core_clk or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         div_q <= 6'h00;
      end else if (!running || state_q == adc_ctrl_pkg::ST_IDLE || tick) begin
         div_q <= 6'h00;
      end else begin
         div_q <= div_q + 6'h01;
      end
   end

   // ==========================================================
   // Sample length: field+1, clamped
   logic [3:0] samp_len;
   always_comb begin
      samp_len = timing_q[3:0] + 4'h1;
      if (timing_q[3:0] == 4'hf) begin
         samp_len = `SAMPLE_MAX;
      end else if (samp_len < `SAMPLE_MIN) begin
         samp_len = `SAMPLE_MIN;
      end
   end

   // ==========================================================
   // Sequencer: sample then twelve bit periods
   logic [3:0] cnt_q;
   always_ff @(posedge core_clk or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         state_q <= adc_ctrl_pkg::ST_IDLE;
         cnt_q   <= 4'h0;
      end else if (!running) begin
         state_q <= adc_ctrl_pkg::ST_IDLE;
         cnt_q   <= 4'h0;
      end else begin
         case (state_q)
            adc_ctrl_pkg::ST_IDLE: begin
               state_q <= adc_ctrl_pkg::ST_SAMPLE;
               cnt_q   <= 4'h0;
            end
            adc_ctrl_pkg::ST_SAMPLE: begin
               if (tick) begin
                  if (cnt_q == samp_len - 4'h1) begin
                     state_q <= adc_ctrl_pkg::ST_CONVERT;
                     cnt_q   <= 4'h0;
                  end else begin
                     cnt_q <= cnt_q + 4'h1;
                  end
               end
            end
            adc_ctrl_pkg::ST_CONVERT: begin
               if (tick) begin
                  if (cnt_q == `CONV_BITS - 4'h1) begin
                     // Compare mode loops for another pass
                     state_q <= adc_ctrl_pkg::ST_IDLE;
                     cnt_q   <= 4'h0;
                  end else begin
                     cnt_q <= cnt_q + 4'h1;
                  end
               end
            end
            default: begin
               state_q <= adc_ctrl_pkg::ST_IDLE;
               cnt_q   <= 4'h0;
            end
         endcase
      end
   end

   logic pass_end;
   assign pass_end = running && state_q == adc_ctrl_pkg::ST_CONVERT && tick
                     && cnt_q == `CONV_BITS - 4'h1;
   assign conv_done = pass_end & ~main_q[`MC_CMP_EN];
   assign cmp_done  = pass_end & main_q[`MC_CMP_EN];
   assign cmp_hit   = cmp_done & (timing_q[4] ? core_below : core_above);
   assign sample_en = (state_q == adc_ctrl_pkg::ST_SAMPLE);
   assign conv_step = (state_q == adc_ctrl_pkg::ST_CONVERT) & tick;

   // ==========================================================
   // Checks
   chk_go_clear_done: assert property (@(posedge core_clk) disable iff (!rst_sync_n_q)
      conv_done && !wr_main |=> !main_q[`MC_GO])
      else $error("go bit not cleared after conversion");
   chk_go_held_cmp: assert property (@(posedge core_clk) disable iff (!rst_sync_n_q)
      cmp_done && !wr_main |=> main_q[`MC_GO])
      else $error("go bit cleared in compare mode");
   chk_abort_idle: assert property (@(posedge core_clk) disable iff (!rst_sync_n_q)
      state_q != adc_ctrl_pkg::ST_IDLE && !running |=> state_q == adc_ctrl_pkg::ST_IDLE)
      else $error("abort did not stop sequencer");
   chk_flag_sets: assert property (@(posedge core_clk) disable iff (!rst_sync_n_q)
      conv_done || cmp_hit |=> flag_q)
      else $error("flag not set on event");
   chk_result_stable: assert property (@(posedge core_clk) disable iff (!rst_sync_n_q)
      !conv_done && !wr_fire |=> $stable(result_q))
      else $error("result changed without cause");
   chk_pin8_ext_ref: assert property (@(posedge core_clk) disable iff (!rst_sync_n_q)
      ext_ref |=> !pin_analog_mode[8])
      else $error("pin8 analog under external reference");
   chk_sample_clamp: assert property (@(posedge core_clk) disable iff (!rst_sync_n_q)
      samp_len >= `SAMPLE_MIN && samp_len <= `SAMPLE_MAX)
      else $error("sample length out of range");
   chk_power_gate: assert property (@(posedge core_clk) disable iff (!rst_sync_n_q)
      !main_q[`MC_POWER] |=> state_q == adc_ctrl_pkg::ST_IDLE)
      else $error("converter active while off");
   chk_div_tick: assert property (@(posedge core_clk) disable iff (!rst_sync_n_q)
      tick |-> div_q == div_len - 6'h01)
      else $error("divider tick misplaced");
   chk_irq_level: assert property (@(posedge core_clk) disable iff (!rst_sync_n_q)
      irq == |(irq_stat_q & irq_mask_q))
      else $error("irq does not follow status");

   cov_conv_done: cover property (@(posedge core_clk) disable iff (!rst_sync_n_q) conv_done);
   cov_cmp_hit:   cover property (@(posedge core_clk) disable iff (!rst_sync_n_q) cmp_hit);
   cov_abort:     cover property (@(posedge core_clk) disable iff (!rst_sync_n_q)
      state_q == adc_ctrl_pkg::ST_CONVERT && !running);

endmodule

// ==== test/adc_core_model.sv ====
/*
 * Behavioural analog front end: channel mux plus converter core.
 * Assumes the control block paces it through adc_enable and sample_en.
 */
`timescale 1ns/1ns

module adc_core_model (
   input  wire logic        core_clk,
   input  wire logic        adc_enable,
   input  wire logic        sample_en,
   input  wire logic [3:0]  chan_code,
   input  wire logic        want_above,
   input  wire logic        want_below,
   output logic      [11:0] core_result,
   output logic             core_above,
   output logic             core_below
);
   // ==========================================
   // Core outputs
   initial begin
      core_result = 12'h000;
      core_above  = 1'b0;
      core_below  = 1'b0;
   end

   // Unsettled while off or sampling: toggle so a stale value is never mistaken for a result
   always @(posedge core_clk) begin
      if (adc_enable !== 1'b1 || sample_en !== 1'b0) begin
         core_result <= ~core_result;
         core_above  <= ~core_above;
         core_below  <= ~core_below;
      end else begin
         // Code depends on the routed channel so a wrong route shows in the result
         core_result <= {chan_code, 8'h3c};
         core_above  <= want_above;
         core_below  <= want_below;
      end
   end
endmodule

// ==== test/sar_adc_control_compare_tb.sv ====
/*
 * Self-checking bench for the converter control block.
 * Assumes the register map and timing of the design header, one clock.
 */
`timescale 1ns/1ns
`include "adc_ctrl_params.svh"

module sar_adc_control_compare_tb;
   // ==========================================
   // Signals
   logic        core_clk, reset_n, read, write, want_above, want_below, irq, waitrequest;
   logic [7:0]  address;
   logic [31:0] writedata, readdata, q;
   logic [3:0]  byteenable, chan_code;
   logic        int_ref_route, ext_ref_pin_en, adc_enable, sample_en, conv_step, core_above, core_below;
   logic [8:0]  pin_analog_mode;
   logic [11:0] core_result;
   int          errors, num_checks, samp_cyc, steps;
   // Row: ext, main, timing, channel code, bit period, sample periods
   typedef struct packed {
      logic [7:0] ext, main, tim;
      logic [3:0] code;
      logic [7:0] tad, samp;
   } row_s;
   row_s        rows [8];
   logic [7:0]  regs [9];
   row_s        r;

   // ==========================================
   // Design and far side
   sar_adc_control_compare u_dut (
      .core_clk(core_clk), .reset_n(reset_n), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .irq(irq), .chan_code(chan_code), .int_ref_route(int_ref_route), .ext_ref_pin_en(ext_ref_pin_en),
      .pin_analog_mode(pin_analog_mode), .adc_enable(adc_enable), .sample_en(sample_en),
      .conv_step(conv_step), .core_result(core_result), .core_above(core_above), .core_below(core_below));
   adc_core_model u_core (
      .core_clk(core_clk), .adc_enable(adc_enable), .sample_en(sample_en), .chan_code(chan_code),
      .want_above(want_above), .want_below(want_below), .core_result(core_result),
      .core_above(core_above), .core_below(core_below));

   // ==========================================
   // Clock and phase monitor
   initial core_clk = 1'b0;
   always #10 core_clk = ~core_clk;
   // Count sample cycles and bit steps of the running conversion
   always @(posedge core_clk) begin
      if (sample_en === 1'b1) samp_cyc <= samp_cyc + 1;
      if (conv_step === 1'b1) steps <= steps + 1;
   end

   // ==========================================
   // Tasks
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One Avalon transfer; request held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      address <= a;
      write <= wr;
      read <= !wr;
      writedata <= {24'h0, d};
      do begin
         @(posedge core_clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      if (n >= 50) errors++;
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      check(q, {24'h0, exp});
   endtask
   // Poll main control until go is back to zero
   task automatic wait_go();
      int n;
      n = 0;
      do begin
         bus(1'b0, `OFS_MAIN_CTRL, 8'h00);
         n++;
      end while (q[0] !== 1'b0 && n < 400);
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ==========================================
   // Watchdog: the whole sequence needs far fewer cycles
   initial begin
      repeat (60000) @(posedge core_clk);
      errors++;
      give_verdict();
   end

   // ==========================================
   // Main sequence
   initial begin
      {reset_n, read, write, want_above, want_below} = 5'h0;
      {address, writedata, errors, num_checks, samp_cyc, steps} = '0;
      byteenable = 4'h1;
      rows = '{'{8'h00, 8'h00, 8'h00, 4'h0, 8'd2, 8'd2}, '{8'h04, 8'h0e, 8'h21, 4'h7, 8'd4, 8'd2},
               '{8'h01, 8'h00, 8'h4e, 4'h8, 8'd6, 8'd15}, '{8'h03, 8'h10, 8'h6f, 4'h8, 8'd8, 8'd15},
               '{8'h02, 8'h00, 8'h87, 4'h0, 8'd12, 8'd8}, '{8'h01, 8'h08, 8'ha2, 4'hc, 8'd16, 8'd3},
               '{8'h05, 8'h0e, 8'hc0, 4'hf, 8'd24, 8'd2}, '{8'h00, 8'h0a, 8'he3, 4'h5, 8'd32, 8'd4}};
      regs = '{8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97, 8'ha0, 8'ha4, 8'h80};
      repeat (5) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      // Reset values, unmapped address reads zero
      foreach (regs[i]) rd(regs[i], `RST_BYTE);
      bus(1'b1, 8'h80, 8'hff);
      rd(8'h80, 8'h00);
      // Pin enables reach the pins; a write without lane 0 is ignored
      bus(1'b1, `OFS_PIN_EN, 8'ha5);
      // Pins follow one register stage behind the write
      repeat (2) @(posedge core_clk);
      check(pin_analog_mode[7:0], 8'ha5);
      byteenable <= 4'h0;
      bus(1'b1, `OFS_PIN_EN, 8'h5a);
      byteenable <= 4'h1;
      rd(`OFS_PIN_EN, 8'ha5);
      // Ordinary conversions: one row per divider code
      foreach (rows[i]) begin
         r = rows[i];
         bus(1'b1, `OFS_CTRL_EXT, r.ext);
         bus(1'b1, `OFS_TIMING, r.tim); // no code reaches 1us at 50 MHz; timing is scaled
         bus(1'b1, `OFS_MAIN_CTRL, r.main | 8'h80);
         repeat (600) @(posedge core_clk);
         check(chan_code, r.code);
         check(int_ref_route, r.code[3:2] == 2'b11);
         check(ext_ref_pin_en, r.main[4]);
         check(pin_analog_mode[8], r.ext[1] & ~r.main[4]);
         samp_cyc = 0;
         steps = 0;
         bus(1'b1, `OFS_MAIN_CTRL, r.main | 8'h81);
         wait_go();
         check(q, {24'h0, r.main | 8'hc0});
         check(samp_cyc, r.samp * r.tad);
         check(steps, 12);
         rd(`OFS_RES_HIGH, {r.code, 4'h3});
         rd(`OFS_RES_LOW, r.ext[2] ? 8'h03 : 8'h0c);
         rd(`OFS_IRQ_STATUS, 8'h01);
         check(irq, 1'b0);
         bus(1'b1, `OFS_MAIN_CTRL, r.main | 8'h80);
      end
      // Abort mid sample: no steps, no flag, result untouched
      bus(1'b1, `OFS_TIMING, 8'hef);
      bus(1'b1, `OFS_MAIN_CTRL, 8'h81);
      repeat (20) @(posedge core_clk);
      bus(1'b1, `OFS_MAIN_CTRL, 8'h80);
      repeat (900) @(posedge core_clk);
      check(sample_en, 1'b0);
      check(steps, 12);
      rd(`OFS_MAIN_CTRL, 8'h80);
      rd(`OFS_IRQ_STATUS, 8'h00);
      rd(`OFS_RES_HIGH, 8'h53);
      // Go without power does nothing
      bus(1'b1, `OFS_MAIN_CTRL, 8'h01);
      repeat (100) @(posedge core_clk);
      check({adc_enable, sample_en}, 2'b00);
      rd(`OFS_IRQ_STATUS, 8'h00);
      // Compare mode, input above the written value
      bus(1'b1, `OFS_RES_HIGH, 8'h55);
      bus(1'b1, `OFS_RES_LOW, 8'h05);
      bus(1'b1, `OFS_IRQ_MASK, 8'h02);
      bus(1'b1, `OFS_TIMING, 8'h00);
      want_above <= 1'b1;
      bus(1'b1, `OFS_MAIN_CTRL, 8'ha0);
      repeat (600) @(posedge core_clk);
      bus(1'b1, `OFS_MAIN_CTRL, 8'ha1);
      repeat (100) @(posedge core_clk);
      rd(`OFS_MAIN_CTRL, 8'he1);
      check(irq, 1'b1);
      rd(`OFS_RES_HIGH, 8'h55);
      rd(`OFS_RES_LOW, 8'h05);
      // Below polarity: above outcome must not set the flag
      bus(1'b1, `OFS_TIMING, 8'h10);
      bus(1'b1, `OFS_MAIN_CTRL, 8'ha1);
      repeat (200) @(posedge core_clk);
      rd(`OFS_MAIN_CTRL, 8'ha1);
      want_below <= 1'b1;
      repeat (100) @(posedge core_clk);
      rd(`OFS_MAIN_CTRL, 8'he1);
      bus(1'b1, `OFS_MAIN_CTRL, 8'ha0);
      repeat (100) @(posedge core_clk);
      check(sample_en, 1'b0);
      bus(1'b0, `OFS_IRQ_STATUS, 8'h00);
      check(q[1], 1'b1);
      rd(`OFS_IRQ_STATUS, 8'h00);
      check(irq, 1'b0);
      // Second reset in mid-run restores defaults
      reset_n <= 1'b0;
      repeat (5) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      check(pin_analog_mode, 9'h000);
      rd(`OFS_PIN_EN, 8'h00);
      give_verdict();
   end
endmodule
